/* logic/gtp_pkg.sv */
// Shared constants, field layout and helpers for the timer block
package gtp_pkg;

   // ==========================================
   // Sizes
   localparam int NTMR = 9;
   localparam int NPAIR = 4;

   // ==========================================
   // Register map, timer i at 16*i
   localparam logic [1:0] F_CTRL = 2'h0;
   localparam logic [1:0] F_COUNT = 2'h1;
   localparam logic [1:0] F_PERIOD = 2'h2;
   localparam logic [7:0] A_STATUS = 8'h90;
   localparam logic [7:0] A_MASK = 8'h94;

   // ==========================================
   // Control field positions
   localparam int B_RUN = 15;
   localparam int B_HALT = 13;
   localparam int B_GATE = 6;
   localparam int B_PRS = 4;
   localparam int B_CASC = 3;
   localparam int B_SYNC = 2;
   localparam int B_SRC = 1;
   localparam logic [15:0] CTRL_MASK = 16'hA07E;

   // ==========================================
   // Reset values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [15:0] PERIOD_RST = 16'hFFFF;
   localparam logic [8:0] MASK_RST = 9'h000;

   // Decoded control word
   typedef struct packed {
      logic run;
      logic halt;
      logic gate;
      logic [1:0] prs;
      logic casc;
      logic sync;
      logic src;
   } gtp_ctrl_s;

   // Unpack a stored control word
   function automatic gtp_ctrl_s to_ctrl(input logic [15:0] w);
      gtp_ctrl_s c;
      c.run = w[B_RUN];
      c.halt = w[B_HALT];
      c.gate = w[B_GATE];
      c.prs = w[B_PRS+1:B_PRS];
      c.casc = w[B_CASC];
      c.sync = w[B_SYNC];
      c.src = w[B_SRC];
      return c;
   endfunction

   // Last prescaler count for divide by 1, 8, 64, 256: 0, 7, 63, 255
   function automatic logic [7:0] pre_last(input logic [1:0] s);
      case (s)
         2'h0: return 8'h00;
         2'h1: return 8'h07;
         2'h2: return 8'h3F;
         default: return 8'hFF;
      endcase
   endfunction

   // Address decode: mapped word or not
   function automatic logic addr_hit(input logic [7:0] a);
      return (a[7:4] < 4'h9 && a[3:2] != 2'h3) || a == A_STATUS || a == A_MASK;
   endfunction

endpackage

/* logic/gtp_timers.sv */
// Standalone timer plus four cascadable timer pairs behind APB
`timescale 1ns/1ps

module gtp_timers (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic idle_mode,
   input wire logic [8:0] ext_clock_pin,
   output logic irq,
   output logic [1:0] adc_trigger,
   output logic [15:0] tb_even_count,
   output logic [15:0] tb_odd_count
);

   // ==========================================
   // State
   logic [15:0] ctl_reg [gtp_pkg::NTMR];
   logic [15:0] ctl_next [gtp_pkg::NTMR];
   logic [15:0] cnt_reg [gtp_pkg::NTMR];
   logic [15:0] cnt_next [gtp_pkg::NTMR];
   logic [15:0] per_reg [gtp_pkg::NTMR];
   logic [15:0] per_next [gtp_pkg::NTMR];
   logic [7:0] pre_reg [gtp_pkg::NTMR];
   logic [7:0] pre_next [gtp_pkg::NTMR];
   logic [8:0] status_reg;
   logic [8:0] status_next;
   logic [8:0] mask_reg;
   logic [8:0] mask_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic pslverr_reg;
   logic pslverr_next;
   logic pready_reg;
   logic irq_reg;
   logic irq_next;
   logic [1:0] adc_reg;
   logic [1:0] adc_next;
   logic [8:0] pin_s1_reg;
   logic [8:0] pin_s2_reg;
   logic [8:0] pin_s3_reg;
   logic [8:0] pin_s4_reg;
   logic [8:0] tick;
   logic [8:0] tin;
   logic [8:0] evt;
   logic [8:0] cnt_wr;
   logic [31:0] rdata;
   logic [31:0] sum32;
   logic wr;
   logic rd_setup;
   logic [3:0] idx;
   logic [1:0] fld;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   // ==========================================
   // Pin synchronisers and edges
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pin_s1_reg <= 9'h000;
         pin_s2_reg <= 9'h000;
         pin_s3_reg <= 9'h000;
         pin_s4_reg <= 9'h000;
      end else begin
         pin_s1_reg <= ext_clock_pin;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_s4_reg <= pin_s3_reg;
      end
   end

   // ==========================================
   // Bus decode
   assign idx = paddr[7:4];
   assign fld = paddr[3:2];
   assign wr = psel & penable & pwrite & gtp_pkg::addr_hit(paddr);
   assign rd_setup = psel & ~penable & ~pwrite;

   // Read multiplexer
   always_comb begin
      rdata = 32'h0000_0000;
      if (paddr == gtp_pkg::A_STATUS) begin
         rdata = {23'h000000, status_reg};
      end else if (paddr == gtp_pkg::A_MASK) begin
         rdata = {23'h000000, mask_reg};
      end else if (gtp_pkg::addr_hit(paddr)) begin
         case (fld)
            gtp_pkg::F_CTRL: rdata = {16'h0000, ctl_reg[idx]};
            gtp_pkg::F_COUNT: rdata = {16'h0000, cnt_reg[idx]};
            default: rdata = {16'h0000, per_reg[idx]};
         endcase
      end
   end

   // ==========================================
   // Timer next state
   always_comb begin
      gtp_pkg::gtp_ctrl_s c;
      int e;
      int o;
      c = '0;
      e = 0;
      o = 0;
      tick = 9'h000;
      tin = 9'h000;
      evt = 9'h000;
      cnt_wr = 9'h000;
      sum32 = 32'h0000_0000;
      for (int i = 0; i < gtp_pkg::NTMR; i++) begin
         ctl_next[i] = ctl_reg[i];
         cnt_next[i] = cnt_reg[i];
         per_next[i] = per_reg[i];
         pre_next[i] = pre_reg[i];
      end
      // Independent 16-bit operation
      for (int i = 0; i < gtp_pkg::NTMR; i++) begin
         c = gtp_pkg::to_ctrl(ctl_reg[i]);
         if (c.src) begin
            tin[i] = c.sync ? (pin_s3_reg[i] & ~pin_s4_reg[i])
                            : (pin_s2_reg[i] & ~pin_s3_reg[i]);
         end else begin
            tin[i] = ~c.gate | pin_s2_reg[i];
         end
         tin[i] = tin[i] & c.run & ~(c.halt & idle_mode);
         tick[i] = tin[i] && pre_reg[i] == gtp_pkg::pre_last(c.prs);
         if (tin[i]) begin
            pre_next[i] = tick[i] ? 8'h00 : 8'(pre_reg[i] + 8'h01);
         end
         if (tick[i]) begin
            if (cnt_reg[i] == per_reg[i]) begin
               cnt_next[i] = 16'h0000;
               evt[i] = 1'b1;
            end else begin
               cnt_next[i] = 16'(cnt_reg[i] + 16'h0001);
            end
         end
      end
      // Cascaded 32-bit pairs
      for (int p = 0; p < gtp_pkg::NPAIR; p++) begin
         e = 2 * p + 1;
         o = 2 * p + 2;
         c = gtp_pkg::to_ctrl(ctl_reg[e]);
         if (c.casc) begin
            pre_next[o] = pre_reg[o];
            cnt_next[o] = cnt_reg[o];
            tick[o] = 1'b0;
            evt[o] = 1'b0;
            evt[e] = 1'b0;
            if (tick[e]) begin
               if ({cnt_reg[o], cnt_reg[e]} == {per_reg[o], per_reg[e]}) begin
                  cnt_next[o] = 16'h0000;
                  cnt_next[e] = 16'h0000;
                  evt[o] = 1'b1;
               end else begin
                  sum32 = {cnt_reg[o], cnt_reg[e]} + 32'h0000_0001;
                  cnt_next[o] = sum32[31:16];
                  cnt_next[e] = sum32[15:0];
               end
            end
         end
      end
      // Software writes take priority over counting
      for (int i = 0; i < gtp_pkg::NTMR; i++) begin
         if (wr && idx == 4'(i)) begin
            case (fld)
               gtp_pkg::F_CTRL: ctl_next[i] = pwdata[15:0] & gtp_pkg::CTRL_MASK;
               gtp_pkg::F_COUNT: begin
                  cnt_next[i] = pwdata[15:0];
                  cnt_wr[i] = 1'b1;
               end
               gtp_pkg::F_PERIOD: per_next[i] = pwdata[15:0];
               default: ;
            endcase
         end
      end
   end

   // ==========================================
   // Interrupts, triggers and bus answer
   always_comb begin
      status_next = status_reg;
      mask_next = mask_reg;
      // Read clears only the bits it returned; new events win
      if (psel && penable && !pwrite && paddr == gtp_pkg::A_STATUS) begin
         status_next = status_reg & ~prdata_reg[8:0];
      end
      status_next = status_next | evt;
      if (wr && paddr == gtp_pkg::A_MASK) begin
         mask_next = pwdata[8:0];
      end
      irq_next = |(status_next & mask_next);
      adc_next = {evt[4], evt[2]};
      prdata_next = rd_setup ? rdata : prdata_reg;
      pslverr_next = pslverr_reg;
      if (psel && !penable) begin
         pslverr_next = ~gtp_pkg::addr_hit(paddr);
      end
   end

   // Register everything
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < gtp_pkg::NTMR; i++) begin
            ctl_reg[i] <= gtp_pkg::CTRL_RST;
            cnt_reg[i] <= gtp_pkg::COUNT_RST;
            per_reg[i] <= gtp_pkg::PERIOD_RST;
            pre_reg[i] <= 8'h00;
         end
         status_reg <= 9'h000;
         mask_reg <= gtp_pkg::MASK_RST;
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
         pready_reg <= 1'b0;
         irq_reg <= 1'b0;
         adc_reg <= 2'h0;
      end else begin
         for (int i = 0; i < gtp_pkg::NTMR; i++) begin
            ctl_reg[i] <= ctl_next[i];
            cnt_reg[i] <= cnt_next[i];
            per_reg[i] <= per_next[i];
            pre_reg[i] <= pre_next[i];
         end
         status_reg <= status_next;
         mask_reg <= mask_next;
         prdata_reg <= prdata_next;
         pslverr_reg <= pslverr_next;
         pready_reg <= 1'b1;
         irq_reg <= irq_next;
         adc_reg <= adc_next;
      end
   end

   // ==========================================
   // Outputs
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign irq = irq_reg;
   assign adc_trigger = adc_reg;
   assign tb_even_count = cnt_reg[1];
   assign tb_odd_count = cnt_reg[2];

   // ==========================================
   // Checks
   chk_stop_hold: assert property (
      !ctl_reg[0][gtp_pkg::B_RUN] && !cnt_wr[0] |=> cnt_reg[0] == $past(cnt_reg[0]))
      else $error("stopped timer count moved");

   chk_idle_halt: assert property (
      idle_mode && ctl_reg[0][gtp_pkg::B_HALT] |-> !tick[0])
      else $error("timer ticked while halted in idle");

   chk_gate_low: assert property (
      ctl_reg[0][gtp_pkg::B_GATE] && !ctl_reg[0][gtp_pkg::B_SRC] && !pin_s2_reg[0]
      |-> !tin[0])
      else $error("gated timer counted with gate low");

   chk_prs_gap: assert property (
      tick[0] && ctl_reg[0][5:4] == 2'h3 && !wr |=> !tick[0] [*8])
      else $error("prescaler 256 ticked too soon");

   chk_wrap_zero: assert property (
      tick[0] && cnt_reg[0] == per_reg[0] && !cnt_wr[0]
      |=> cnt_reg[0] == 16'h0000 && status_reg[0])
      else $error("match did not wrap and flag");

   chk_casc_flag: assert property (
      ctl_reg[1][gtp_pkg::B_CASC] |-> !evt[1] && !tick[2])
      else $error("cascaded even timer flagged");

   chk_casc_carry: assert property (
      ctl_reg[1][gtp_pkg::B_CASC] && tick[1] && cnt_reg[1] == 16'hFFFF
      && {cnt_reg[2], cnt_reg[1]} != {per_reg[2], per_reg[1]} && cnt_wr[2:1] == 2'h0
      |=> cnt_reg[2] == 16'($past(cnt_reg[2]) + 16'h0001) && cnt_reg[1] == 16'h0000)
      else $error("carry into high word lost");

   chk_adc_trig: assert property (
      evt[2] |=> adc_trigger[0] ##1 !adc_trigger[0] || $past(evt[2]))
      else $error("ADC trigger pulse wrong");

   chk_irq_level: assert property (
      ##1 (evt != 9'h000 && (evt & mask_reg) != 9'h000 && !wr) |=> irq)
      else $error("unmasked event raised no interrupt");

endmodule // gtp_timers

/* testbench/gtp_pin_model.sv */
// Behavioural driver for the external clock and gate pins
`timescale 1ns/1ps
module gtp_pin_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [8:0] clk_en,
   input wire logic [8:0] level,
   output logic [8:0] ext_clock_pin
);
   logic [2:0] div_reg;
   // ==========================================
   // Pin clock of eight core cycles, held still where not enabled
   always_ff @(posedge core_clk) begin
      div_reg <= rst_n ? div_reg + 3'h1 : 3'h0;
      ext_clock_pin <= (clk_en & {9{div_reg[2]}}) | (~clk_en & level);
   end
endmodule // gtp_pin_model

/* testbench/tb_gtp_timers.sv */
// Self-checking bench for the timer block
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
$display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb_gtp_timers;
   logic core_clk, rst_n, psel, penable, pwrite, idle_mode, irq, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, a;
   logic [8:0] pm_en, pm_lvl, pins;
   logic [1:0] adc_trigger;
   logic [15:0] tb_even_count, tb_odd_count;
   int err_count, checks_done, n;
   int sh [4] = '{0, 3, 6, 8};
   // ==========================================
   // Design and pin model
   gtp_timers uut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .idle_mode(idle_mode), .ext_clock_pin(pins), .irq(irq),
      .adc_trigger(adc_trigger), .tb_even_count(tb_even_count), .tb_odd_count(tb_odd_count));
   gtp_pin_model pm (.core_clk(core_clk), .rst_n(rst_n), .clk_en(pm_en), .level(pm_lvl),
      .ext_clock_pin(pins));
   // Clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ==========================================
   // Verdict and end of run
   task final_report;
      $display("Checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // One APB transfer, read data left in rd
   task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         err_count++;
         final_report;
      end else begin
         rd = prdata;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // Count advance of one timer over 512 cycles
   task rate(input logic [7:0] b, input logic [15:0] c, input logic [15:0] e);
      xfer(1'b1, b, {16'h0000, c});
      repeat (300) @(posedge core_clk);
      xfer(1'b0, b + 8'h04, 32'h0);
      a = rd;
      repeat (509) @(posedge core_clk);
      xfer(1'b0, b + 8'h04, 32'h0);
      `CHK(rd[15:0] - a[15:0], e)
   endtask
   // Bounded wait for an ADC trigger pulse
   task wait_trig(input int k);
      n = 0;
      while (adc_trigger[k] !== 1'b1 && n < 200) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 200) begin
         err_count++;
         final_report;
      end
   endtask
   // ==========================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      {psel, penable, pwrite, idle_mode} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pm_en = 9'h000;
      pm_lvl = 9'h000;
      err_count = 0;
      checks_done = 0;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      // Reset values, reserved bits, unmapped address
      xfer(1'b0, 8'h08, 32'h0);
      `CHK(rd, 32'h0000FFFF)
      xfer(1'b0, gtp_pkg::A_MASK, 32'h0);
      `CHK(rd, 32'h00000000)
      xfer(1'b0, 8'hA0, 32'h0);
      `CHK({pslverr, rd}, 33'h100000000)
      xfer(1'b1, 8'h50, 32'hFFFF7FFF);
      xfer(1'b0, 8'h50, 32'h0);
      `CHK(rd, 32'h0000207E)
      xfer(1'b1, 8'h50, 32'h0);
      // Prescale codes, stop, idle, gate, external clock
      for (int i = 0; i < 4; i++) rate(8'h00, 16'h8000 | 16'(i << 4), 16'd512 >> sh[i]);
      rate(8'h00, 16'h0000, 16'd0);
      idle_mode <= 1'b1;
      rate(8'h00, 16'hA000, 16'd0);
      rate(8'h00, 16'h8000, 16'd512);
      idle_mode <= 1'b0;
      rate(8'h00, 16'h8040, 16'd0);
      pm_lvl <= 9'h001;
      rate(8'h00, 16'h8040, 16'd512);
      pm_lvl <= 9'h000;
      pm_en <= 9'h001;
      rate(8'h00, 16'h8042, 16'd64);
      rate(8'h00, 16'h8046, 16'd64);
      pm_en <= 9'h000;
      rate(8'h30, 16'h8000, 16'd512);
      xfer(1'b1, 8'h30, 32'h0);
      // Period match, sticky status, mask and irq
      xfer(1'b1, 8'h04, 32'h0);
      xfer(1'b1, 8'h08, 32'h4);
      xfer(1'b1, 8'h00, 32'h8000);
      xfer(1'b0, 8'h04, 32'h0);
      `CHK(rd[15:0] <= 16'h0004, 1'b1)
      // Let the first match land before status is latched
      repeat (4) @(posedge core_clk);
      xfer(1'b0, gtp_pkg::A_STATUS, 32'h0);
      `CHK(rd[0], 1'b1)
      `CHK(irq, 1'b0)
      xfer(1'b1, gtp_pkg::A_MASK, 32'h1);
      repeat (10) @(negedge core_clk);
      `CHK(irq, 1'b1)
      xfer(1'b1, 8'h00, 32'h0);
      xfer(1'b0, gtp_pkg::A_STATUS, 32'h0);
      xfer(1'b0, gtp_pkg::A_STATUS, 32'h0);
      `CHK(rd[8:0], 9'h000)
      @(negedge core_clk);
      `CHK(irq, 1'b0)
      // Cascaded pair 0, odd control set but ignored
      xfer(1'b1, 8'h10, 32'h0008);
      xfer(1'b1, 8'h20, 32'h8030);
      xfer(1'b1, 8'h14, 32'hFFF0);
      xfer(1'b1, 8'h24, 32'h0);
      xfer(1'b1, 8'h18, 32'h5);
      xfer(1'b1, 8'h28, 32'h1);
      xfer(1'b1, gtp_pkg::A_MASK, 32'h6);
      xfer(1'b1, 8'h10, 32'h8008);
      wait_trig(0);
      `CHK({tb_odd_count, tb_even_count}, 32'h0)
      `CHK(adc_trigger[1], 1'b0)
      `CHK(irq, 1'b1)
      xfer(1'b0, gtp_pkg::A_STATUS, 32'h0);
      `CHK(rd[8:0], 9'h004)
      xfer(1'b1, 8'h10, 32'h0);
      // Pair 1 in 16-bit mode triggers the second ADC
      xfer(1'b1, 8'h48, 32'h2);
      xfer(1'b1, 8'h40, 32'h8000);
      wait_trig(1);
      `CHK(adc_trigger[0], 1'b0)
      xfer(1'b1, 8'h40, 32'h0);
      final_report;
   end
endmodule // tb_gtp_timers
